/* src/pphl_cfg.svh */
/*
 Constants for the printer-port host link: bus window, commands, register
 offsets and fields. Assumes inclusion by bare name from the package.
*/
`ifndef PPHL_CFG_SVH
`define PPHL_CFG_SVH

`define PPHL_HOST_BASE   24'hFF_F000
`define PPHL_HOST_PAGE   12'hFFF
`define PPHL_CMD_WRITE   32'h0000_0001
`define PPHL_CMD_READ    32'h0000_0002
`define PPHL_CMD_CTX     32'h0000_0003
`define PPHL_CMD_RUN     32'h0000_0004
`define PPHL_CMD_STEP    32'h0000_0005
`define PPHL_CMD_HALT    32'h0000_0006
`define PPHL_CTX_BUF     32'h0000_0030
`define PPHL_MEM_AW      6
`define PPHL_MEM_DEPTH   64
`define PPHL_REG_CTRL    4'h0
`define PPHL_REG_STATUS  4'h4
`define PPHL_CTRL_NIB    0
`define PPHL_CTRL_RST    1'b0
`define PPHL_STAT_RUN    0
`define PPHL_STAT_BUSY   1
`define PPHL_STAT_BOOT   2
`define PPHL_STAT_CMD    8

`endif

/* src/pphl_decode.sv */
/*
 Address decode and byte handshake between the internal bus and the
 printer-port pins. Assumes host pins are asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pphl_cfg.svh"

module pphl_decode import pphl_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [23:0] bus_addr,
	input  wire logic        bus_req,
	input  wire logic        bus_wr,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata,
	output logic             bus_done,
	input  wire logic        host_strobe_line,
	input  wire logic [7:0]  host_data_in,
	input  wire logic        disconnect,
	output logic             host_acknowledge_line,
	output logic      [7:0]  host_data_out,
	output logic             host_data_oe_n,
	output logic             proc_ready,
	output logic             proc_ready_oe_n,
	output logic             host_request_irq,
	output logic             irq_oe_n
);
	logic       stb_s1_q, stb_s2_q, stb_s3_q;
	logic [7:0] dat_s1_q, dat_s2_q;
	logic       dis_s1_q, dis_s2_q;
	logic       lock_q, irq_q;
	logic       rise, fall, sel;

	function automatic logic in_host_range(input logic [23:0] a);
		in_host_range = (a[23:12] == `PPHL_HOST_PAGE);
	endfunction

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stb_s1_q <= 1'b1;
			stb_s2_q <= 1'b1;
			stb_s3_q <= 1'b1;
			dat_s1_q <= 8'h00;
			dat_s2_q <= 8'h00;
			dis_s1_q <= 1'b0;
			dis_s2_q <= 1'b0;
		end else begin
			stb_s1_q <= host_strobe_line;
			stb_s2_q <= stb_s1_q;
			stb_s3_q <= stb_s2_q;
			dat_s1_q <= host_data_in;
			dat_s2_q <= dat_s1_q;
			dis_s1_q <= disconnect;
			dis_s2_q <= dis_s1_q;
		end
	end

	assign rise = stb_s2_q & ~stb_s3_q;
	assign fall = ~stb_s2_q & stb_s3_q;
	assign sel  = bus_req & in_host_range(bus_addr);

	// lock holds the bus cycle until the host strobe comes back up
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			lock_q <= 1'b0;
		else if (lock_q && rise)
			lock_q <= 1'b0;
		else if (sel)
			lock_q <= 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata     <= 8'h00;
			host_data_out <= 8'h00;
			irq_q         <= 1'b0;
		end else begin
			irq_q <= fall;
			// track the synced byte while stalled: the link takes bus_rdata
			// on the release edge, so it must already sit in the flop then
			if (lock_q && !bus_wr)
				bus_rdata <= dat_s2_q;
			if (sel && bus_wr && !lock_q)
				host_data_out <= bus_wdata;
		end
	end

	assign bus_done              = lock_q & rise;
	assign proc_ready            = lock_q & ~rise;
	assign host_acknowledge_line = ~lock_q;
	assign host_data_oe_n        = ~(lock_q & bus_wr);
	assign host_request_irq      = irq_q;
	// the transceiver side keeps running; only the two bus outputs float
	assign proc_ready_oe_n       = dis_s2_q;
	assign irq_oe_n              = dis_s2_q;

	property p_lock_on_sel;
		@(posedge clk) disable iff (!reset_n)
		(sel && !lock_q) |=> (lock_q && !host_acknowledge_line);
	endproperty
	a_lock_on_sel: assert property (p_lock_on_sel)
		else $error("host window access did not lock the bus");

	property p_stall;
		@(posedge clk) disable iff (!reset_n)
		(lock_q && !rise) |-> (proc_ready && !host_acknowledge_line);
	endproperty
	a_stall: assert property (p_stall)
		else $error("locked access not stalled with acknowledge");

	property p_release;
		@(posedge clk) disable iff (!reset_n)
		(lock_q && rise) |-> (!proc_ready && bus_done) ##1 !lock_q;
	endproperty
	a_release: assert property (p_release)
		else $error("strobe rise did not release the bus");

	property p_irq_pulse;
		@(posedge clk) disable iff (!reset_n)
		$fell(stb_s2_q) |=> host_request_irq ##1 !host_request_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("falling strobe did not pulse the request");

	property p_float;
		@(posedge clk) disable iff (!reset_n)
		disconnect [*3] |-> (proc_ready_oe_n && irq_oe_n);
	endproperty
	a_float: assert property (p_float)
		else $error("outputs not floated while disconnected");

endmodule

`default_nettype wire

/* src/pphl_link.sv */
/*
 Printer-port host link: boot loader, packet receiver and command engine
 behind the decode. Assumes the host follows the strobe handshake and
 that bp_hit comes from logic on clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pphl_cfg.svh"

// Behaviour
// - bus addresses 0xFFF000 to 0xFFFFFF select the host port.
// - host strobe falls; that edge pulses the host request interrupt.
// - request interrupt is used for the first byte of each packet only, then ignored.
// - read at 0xFFF000 drives acknowledge low and stalls ready.
// - host strobe rise releases ready and ends the stalled read.
// - four bytes host to device, least significant first, form one word.
// - write at 0xFFF000 drives acknowledge low and stalls ready.
// - host strobe rise releases ready and ends the stalled write.
// - device sends four bytes or eight nibbles, least significant first.
// - boot skips the third and fourth bytes of the first word.
// - disconnect floats the interrupt and ready outputs.
// - packet header is command, length, address, index, then data.
// - after each item the address advances by the index.
// - on a request, save state, take the packet, then dispatch.
// - block write stores length items from the address with stepping.
// - block read sends length items from the address with stepping.
// - context pointer command returns the context buffer address.
// - free run restores and runs until breakpoint or halt.
// - single step restores, runs one instruction, then saves again.
// - halt saves context and waits for the next command.
module pphl_link import pphl_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        host_strobe_line,
	input  wire logic        host_init_n,
	input  wire logic [7:0]  host_data_in,
	output logic      [7:0]  host_data_out,
	output logic             host_data_oe_n,
	output logic             host_acknowledge_line,
	input  wire logic        disconnect,
	output logic             proc_ready,
	output logic             proc_ready_oe_n,
	output logic             host_request_irq,
	output logic             irq_oe_n,
	input  wire logic        bp_hit,
	output logic             cpu_running,
	output logic             ctx_save,
	output logic             ctx_restore,
	output logic             step_pulse
);
	pphl_state_e state_q;
	logic [31:0] mem [0:`PPHL_MEM_DEPTH-1];
	logic [31:0] cmd_q, len_q, addr_q, index_q, rx_q, tx_q;
	logic [1:0]  hdr_idx_q, byte_idx_q, last_q;
	logic        busy_q, dir_q, half_q, word_done_q;
	logic        running_q, saved_run_q, ctx_save_q, restore_q, step_q;
	logic        nib_q;
	logic        init_s1_q, init_s2_q, init_s3_q, init_rise;
	logic        start, start_wr, free;
	logic [1:0]  start_last;
	logic [31:0] tx_word;
	logic [7:0]  tx_byte, bus_wdata, bus_rdata;
	logic        bus_done, last_access;
	logic [`PPHL_MEM_AW-1:0] mem_idx;

	pphl_decode u_decode (
		.clk                   (clk),
		.reset_n               (reset_n),
		.bus_addr              (`PPHL_HOST_BASE),
		.bus_req               (busy_q),
		.bus_wr                (dir_q),
		.bus_wdata             (bus_wdata),
		.bus_rdata             (bus_rdata),
		.bus_done              (bus_done),
		.host_strobe_line      (host_strobe_line),
		.host_data_in          (host_data_in),
		.disconnect            (disconnect),
		.host_acknowledge_line (host_acknowledge_line),
		.host_data_out         (host_data_out),
		.host_data_oe_n        (host_data_oe_n),
		.proc_ready            (proc_ready),
		.proc_ready_oe_n       (proc_ready_oe_n),
		.host_request_irq      (host_request_irq),
		.irq_oe_n              (irq_oe_n)
	);

	// host reset bit arrives asynchronously
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			init_s1_q <= 1'b1;
			init_s2_q <= 1'b1;
			init_s3_q <= 1'b1;
		end else begin
			init_s1_q <= host_init_n;
			init_s2_q <= init_s1_q;
			init_s3_q <= init_s2_q;
		end
	end
	assign init_rise = init_s2_q & ~init_s3_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			nib_q <= `PPHL_CTRL_RST;
		else if (reg_wr && reg_addr == `PPHL_REG_CTRL)
			nib_q <= reg_wdata[`PPHL_CTRL_NIB];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd && reg_addr == `PPHL_REG_CTRL)
				reg_rdata[`PPHL_CTRL_NIB] <= nib_q;
			else if (reg_rd && reg_addr == `PPHL_REG_STATUS) begin
				reg_rdata[`PPHL_STAT_RUN]  <= running_q;
				reg_rdata[`PPHL_STAT_BUSY] <= (state_q != S_IDLE);
				reg_rdata[`PPHL_STAT_BOOT] <= (state_q == S_BOOT_LEN) ||
					(state_q == S_BOOT_DATA);
				reg_rdata[`PPHL_STAT_CMD +: 8] <= cmd_q[7:0];
			end
		end
	end

	assign mem_idx = addr_q[`PPHL_MEM_AW-1:0];
	assign free    = !busy_q && !word_done_q;

	always_comb begin
		start      = 1'b0;
		start_wr   = 1'b0;
		start_last = 2'd3;
		tx_word    = 32'h0000_0000;
		case (state_q)
			S_BOOT_LEN: begin
				start      = free;
				start_last = 2'd1;
			end
			S_BOOT_DATA, S_WR_DATA:
				start = free && (len_q != 32'h0000_0000);
			S_HDR:
				start = free;
			S_RD_DATA: begin
				start    = free && (len_q != 32'h0000_0000);
				start_wr = 1'b1;
				tx_word  = mem[mem_idx];
			end
			S_SEND_CTX: begin
				start    = free;
				start_wr = 1'b1;
				tx_word  = `PPHL_CTX_BUF;
			end
			default: ;
		endcase
	end

	// nibble mode: low nibble of each byte goes out first
	assign tx_byte     = tx_q[{byte_idx_q, 3'b000} +: 8];
	assign bus_wdata   = (nib_q && dir_q) ?
		{4'h0, half_q ? tx_byte[7:4] : tx_byte[3:0]} : tx_byte;
	assign last_access = (byte_idx_q == last_q) &&
		(!(nib_q && dir_q) || half_q);

	// word transfer: one bus access per byte or nibble
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q      <= 1'b0;
			dir_q       <= 1'b0;
			half_q      <= 1'b0;
			byte_idx_q  <= 2'd0;
			last_q      <= 2'd3;
			word_done_q <= 1'b0;
			rx_q        <= 32'h0000_0000;
			tx_q        <= 32'h0000_0000;
		end else begin
			word_done_q <= 1'b0;
			if (init_rise) begin
				busy_q <= 1'b0;
			end else if (start) begin
				busy_q     <= 1'b1;
				dir_q      <= start_wr;
				last_q     <= start_last;
				byte_idx_q <= 2'd0;
				half_q     <= 1'b0;
				rx_q       <= 32'h0000_0000;
				tx_q       <= tx_word;
			end else if (busy_q && bus_done) begin
				if (!dir_q)
					rx_q[{byte_idx_q, 3'b000} +: 8] <= bus_rdata;
				if (last_access) begin
					busy_q      <= 1'b0;
					word_done_q <= 1'b1;
				end else if (nib_q && dir_q && !half_q) begin
					half_q <= 1'b1;
				end else begin
					half_q     <= 1'b0;
					byte_idx_q <= byte_idx_q + 2'd1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if ((state_q == S_BOOT_DATA || state_q == S_WR_DATA) && word_done_q)
			mem[mem_idx] <= rx_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= S_IDLE;
			hdr_idx_q   <= 2'd0;
			cmd_q       <= 32'h0000_0000;
			len_q       <= 32'h0000_0000;
			addr_q      <= 32'h0000_0000;
			index_q     <= 32'h0000_0000;
			running_q   <= 1'b0;
			saved_run_q <= 1'b0;
			ctx_save_q  <= 1'b0;
			restore_q   <= 1'b0;
			step_q      <= 1'b0;
		end else begin
			ctx_save_q <= 1'b0;
			restore_q  <= 1'b0;
			step_q     <= 1'b0;
			if (init_rise) begin
				state_q   <= S_BOOT_LEN;
				running_q <= 1'b0;
			end else begin
				case (state_q)
					S_IDLE: begin
						if (host_request_irq) begin
							saved_run_q <= running_q;
							running_q   <= 1'b0;
							ctx_save_q  <= 1'b1;
							hdr_idx_q   <= 2'd0;
							state_q     <= S_HDR;
						end else if (running_q && bp_hit) begin
							running_q  <= 1'b0;
							ctx_save_q <= 1'b1;
						end
					end
					S_BOOT_LEN: if (word_done_q) begin
						len_q   <= {16'h0000, rx_q[15:0]};
						addr_q  <= 32'h0000_0000;
						index_q <= 32'h0000_0001;
						state_q <= S_BOOT_DATA;
					end
					S_BOOT_DATA: begin
						if (len_q == 32'h0000_0000)
							state_q <= S_IDLE;
						else if (word_done_q) begin
							addr_q <= addr_q + index_q;
							len_q  <= len_q - 32'h0000_0001;
						end
					end
					// later request pulses in a packet fall through here
					S_HDR: if (word_done_q) begin
						case (hdr_idx_q)
							2'd0: cmd_q   <= rx_q;
							2'd1: len_q   <= rx_q;
							2'd2: addr_q  <= rx_q;
							default: index_q <= rx_q;
						endcase
						hdr_idx_q <= hdr_idx_q + 2'd1;
						if (hdr_idx_q == 2'd3)
							state_q <= S_DISPATCH;
					end
					S_DISPATCH: begin
						case (cmd_q)
							`PPHL_CMD_WRITE: state_q <= S_WR_DATA;
							`PPHL_CMD_READ:  state_q <= S_RD_DATA;
							`PPHL_CMD_CTX:   state_q <= S_SEND_CTX;
							`PPHL_CMD_RUN: begin
								restore_q <= 1'b1;
								running_q <= 1'b1;
								state_q   <= S_IDLE;
							end
							`PPHL_CMD_STEP: begin
								restore_q <= 1'b1;
								step_q    <= 1'b1;
								state_q   <= S_STEP;
							end
							`PPHL_CMD_HALT: begin
								running_q <= 1'b0;
								state_q   <= S_IDLE;
							end
							default: begin
								running_q <= saved_run_q;
								restore_q <= 1'b1;
								state_q   <= S_IDLE;
							end
						endcase
					end
					S_WR_DATA, S_RD_DATA: begin
						if (len_q == 32'h0000_0000) begin
							running_q <= saved_run_q;
							restore_q <= 1'b1;
							state_q   <= S_IDLE;
						end else if (word_done_q) begin
							addr_q <= addr_q + index_q;
							len_q  <= len_q - 32'h0000_0001;
						end
					end
					S_SEND_CTX: if (word_done_q) begin
						running_q <= saved_run_q;
						restore_q <= 1'b1;
						state_q   <= S_IDLE;
					end
					S_STEP: begin
						ctx_save_q <= 1'b1;
						running_q  <= 1'b0;
						state_q    <= S_IDLE;
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	assign cpu_running = running_q;
	assign ctx_save    = ctx_save_q;
	assign ctx_restore = restore_q;
	assign step_pulse  = step_q;

	property p_boot_skip;
		@(posedge clk) disable iff (!reset_n)
		(state_q == S_BOOT_LEN && word_done_q) |-> (byte_idx_q == 2'd1);
	endproperty
	a_boot_skip: assert property (p_boot_skip)
		else $error("boot length word did not stop after two bytes");

	property p_lsb_first;
		@(posedge clk) disable iff (!reset_n)
		(busy_q && !dir_q && bus_done && byte_idx_q == 2'd0) |=>
			(rx_q[7:0] == $past(bus_rdata) && rx_q[31:8] == 24'h00_0000);
	endproperty
	a_lsb_first: assert property (p_lsb_first)
		else $error("first received byte not in low lane");

	property p_index_step;
		@(posedge clk) disable iff (!reset_n)
		(state_q == S_WR_DATA && word_done_q && !init_rise) |=>
			(addr_q == $past(addr_q) + $past(index_q));
	endproperty
	a_index_step: assert property (p_index_step)
		else $error("address not stepped by index");

	property p_irq_ignored;
		@(posedge clk) disable iff (!reset_n)
		(host_request_irq && state_q == S_HDR && !word_done_q &&
			!init_rise) |=> (state_q == S_HDR && !ctx_save_q);
	endproperty
	a_irq_ignored: assert property (p_irq_ignored)
		else $error("request inside a packet was acted on");

	property p_step_save;
		@(posedge clk) disable iff (!reset_n)
		(step_q && !init_rise) |-> ctx_restore ##1 (ctx_save && !cpu_running);
	endproperty
	a_step_save: assert property (p_step_save)
		else $error("single step did not save context after one cycle");

	property p_bp_stop;
		@(posedge clk) disable iff (!reset_n)
		(state_q == S_IDLE && running_q && bp_hit && !host_request_irq &&
			!init_rise) |=> (!cpu_running && ctx_save);
	endproperty
	a_bp_stop: assert property (p_bp_stop)
		else $error("breakpoint did not stop the run");

endmodule

`default_nettype wire

/* src/pphl_pkg.sv */
/*
 Types for the printer-port host link. Assumes pphl_cfg.svh on the
 include path.
*/
`include "pphl_cfg.svh"

package pphl_pkg;
	typedef enum logic [3:0] {
		S_IDLE,
		S_BOOT_LEN,
		S_BOOT_DATA,
		S_HDR,
		S_DISPATCH,
		S_WR_DATA,
		S_RD_DATA,
		S_SEND_CTX,
		S_STEP
	} pphl_state_e;
endpackage

/* test/pphl_host_model.sv */
/*
 Host printer-port model: drives strobe, init and data lines of the link.
 Assumes one bench process calls its tasks, one transfer at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module pphl_host_model (
	input  wire logic       clk,
	input  wire logic       ack,
	input  wire logic [7:0] dev_data,
	input  wire logic       nib_mode,
	output logic            strobe,
	output logic            init_n,
	output logic      [7:0] data,
	output logic            hang
);
	initial begin
		strobe = 1'b1;
		init_n = 1'b1;
		data   = 8'h00;
		hang   = 1'b0;
	end

	// bounded, so a dead link ends the run instead of hanging
	task automatic wait_ack(input logic lvl);
		int n;
		n = 0;
		while (ack !== lvl && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (ack !== lvl)
			hang <= 1'b1;
	endtask

	task automatic pulse_init();
		@(posedge clk);
		init_n <= 1'b0;
		repeat (4) @(posedge clk);
		init_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic send_byte(input logic [7:0] b);
		@(posedge clk);
		data   <= b;
		@(posedge clk);
		strobe <= 1'b0;
		wait_ack(1'b0);
		repeat (4) @(posedge clk);
		strobe <= 1'b1;
		wait_ack(1'b1);
		@(posedge clk);
		// no pull-ups on the data lines: released byte must not linger
		data   <= ~b;
	endtask

	task automatic send_word(input logic [31:0] w, input int nbytes);
		int k;
		for (k = 0; k < nbytes; k++)
			send_byte(w[8*k +: 8]);
	endtask

	task automatic recv_word(output logic [31:0] w);
		int k;
		int steps;
		steps = nib_mode ? 8 : 4;
		w = '0;
		for (k = 0; k < steps; k++) begin
			wait_ack(1'b0);
			@(posedge clk);
			strobe <= 1'b0;
			repeat (4) @(posedge clk);
			if (nib_mode)
				w[4*k +: 4] = dev_data[3:0];
			else
				w[8*k +: 8] = dev_data;
			strobe <= 1'b1;
			wait_ack(1'b1);
		end
	endtask
endmodule

`default_nettype wire

/* test/printer_port_host_link_tb_top.sv */
/*
 Bench for the printer-port host link: boot, packets, commands, registers.
 Assumes pphl_host_model plays the host and pphl_cfg.svh is reachable.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pphl_cfg.svh"

module printer_port_host_link_tb_top;
	logic        clk;
	logic        reset_n;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        strobe;
	logic        init_n;
	logic [7:0]  hd_in;
	logic [7:0]  hd_out;
	logic        ack;
	logic        oe_n;
	logic        disconnect;
	logic        ready;
	logic        ready_oe_n;
	logic        irq;
	logic        irq_oe_n;
	logic        bp_hit;
	logic        running;
	logic        ctx_save;
	logic        ctx_restore;
	logic        step_pulse;
	logic        hang;
	logic        nib;
	logic        step_q;
	logic [31:0] mem_exp [0:63];
	logic [31:0] w;
	logic [31:0] st;
	int          failures;
	int          checks_done;
	int          n_irq;
	int          n_step;
	int          n_save;
	int          n_drv;
	int          i;
	int          it;
	int          base;
	int          idx;
	int          len;

	pphl_link DUT (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .host_strobe_line(strobe),
		.host_init_n(init_n), .host_data_in(hd_in), .host_data_out(hd_out),
		.host_data_oe_n(oe_n), .host_acknowledge_line(ack),
		.disconnect(disconnect), .proc_ready(ready),
		.proc_ready_oe_n(ready_oe_n), .host_request_irq(irq),
		.irq_oe_n(irq_oe_n), .bp_hit(bp_hit), .cpu_running(running),
		.ctx_save(ctx_save), .ctx_restore(ctx_restore),
		.step_pulse(step_pulse)
	);

	pphl_host_model u_host (
		.clk(clk), .ack(ack), .dev_data(hd_out), .nib_mode(nib),
		.strobe(strobe), .init_n(init_n), .data(hd_in), .hang(hang)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic int item_addr(int b, int x, int k);
		return (b + x * k) % 64;
	endfunction

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// busy is polled over the register port, never waited on blindly
	task automatic wait_idle();
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'hFFFF_FFFF;
		while (s[`PPHL_STAT_BUSY] !== 1'b0 && n < 100) begin
			reg_read(`PPHL_REG_STATUS, s);
			n++;
		end
		if (s[`PPHL_STAT_BUSY] !== 1'b0) begin
			failures++;
			finish_test();
		end
	endtask

	task automatic send_hdr(input logic [31:0] cmd, len, adr, inc);
		u_host.send_word(cmd, 4);
		u_host.send_word(len, 4);
		u_host.send_word(adr, 4);
		u_host.send_word(inc, 4);
	endtask

	always @(posedge hang) begin
		failures++;
		finish_test();
	end

	always @(negedge clk) begin
		if (reset_n) begin
			if (irq === 1'b1)
				n_irq++;
			if (ctx_save === 1'b1)
				n_save++;
			if (ready === 1'b1)
				check(ack, 1'b0);
			if (ack === 1'b1)
				check(oe_n, 1'b1);
			else if (oe_n === 1'b0)
				n_drv++;
			if (step_pulse === 1'b1) begin
				n_step++;
				check(ctx_restore, 1'b1);
			end
			if (step_q === 1'b1)
				check(ctx_save, 1'b1);
		end
		step_q = step_pulse;
	end

	initial begin
		reset_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		disconnect = 1'b0;
		bp_hit = 1'b0;
		nib = 1'b0;
		void'($urandom(43));
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check(ack, 1'b1);
		check(irq, 1'b0);
		reg_read(`PPHL_REG_CTRL, w);
		check(w, 32'h0000_0000);
		reg_write(`PPHL_REG_STATUS, 32'hFFFF_FFFF);
		reg_read(`PPHL_REG_STATUS, w);
		check(w, 32'h0000_0000);
		reg_read(4'h8, w);
		check(w, 32'h0000_0000);
		u_host.pulse_init();
		reg_read(`PPHL_REG_STATUS, st);
		check(st[`PPHL_STAT_BOOT], 1'b1);
		u_host.send_word(32'h0000_0002, 2);
		for (i = 0; i < 2; i++) begin
			mem_exp[i] = $urandom();
			u_host.send_word(mem_exp[i], 4);
		end
		wait_idle();
		reg_read(`PPHL_REG_STATUS, st);
		check(st[`PPHL_STAT_BOOT], 1'b0);
		for (it = 0; it < 3; it++) begin
			base = (it == 0) ? 62 : $urandom_range(40, 8);
			idx  = (it == 0) ? 1 : $urandom_range(4, 0);
			len  = (it == 0) ? 2 : $urandom_range(4, 1);
			send_hdr(`PPHL_CMD_WRITE, len, base, idx);
			for (i = 0; i < len; i++) begin
				w = $urandom();
				mem_exp[item_addr(base, idx, i)] = w;
				u_host.send_word(w, 4);
			end
			wait_idle();
			reg_read(`PPHL_REG_STATUS, st);
			check(st[15:8], 8'h01);
			send_hdr(`PPHL_CMD_READ, len, base, idx);
			for (i = 0; i < len; i++) begin
				u_host.recv_word(w);
				check(w, mem_exp[item_addr(base, idx, i)]);
			end
			wait_idle();
		end
		check(n_irq > 0, 1'b1);
		reg_write(`PPHL_REG_CTRL, 32'h0000_0001);
		reg_read(`PPHL_REG_CTRL, w);
		check(w, 32'h0000_0001);
		nib = 1'b1;
		send_hdr(`PPHL_CMD_READ, 2, 0, 1);
		for (i = 0; i < 2; i++) begin
			u_host.recv_word(w);
			check(w, mem_exp[i]);
		end
		wait_idle();
		reg_write(`PPHL_REG_CTRL, 32'h0000_0000);
		nib = 1'b0;
		send_hdr(`PPHL_CMD_CTX, 0, 0, 0);
		u_host.recv_word(w);
		check(w, `PPHL_CTX_BUF);
		wait_idle();
		send_hdr(`PPHL_CMD_STEP, 0, 0, 0);
		wait_idle();
		check(n_step, 1);
		send_hdr(`PPHL_CMD_RUN, 0, 0, 0);
		wait_idle();
		check(running, 1'b1);
		len = n_save;
		@(posedge clk);
		bp_hit <= 1'b1;
		@(posedge clk);
		bp_hit <= 1'b0;
		for (i = 0; i < 20 && running !== 1'b0; i++)
			@(posedge clk);
		check(running, 1'b0);
		check(n_save > len, 1'b1);
		send_hdr(`PPHL_CMD_RUN, 0, 0, 0);
		wait_idle();
		len = n_save;
		send_hdr(`PPHL_CMD_HALT, 0, 0, 0);
		wait_idle();
		check(running, 1'b0);
		check(n_save > len, 1'b1);
		@(posedge clk);
		disconnect <= 1'b1;
		repeat (4) @(posedge clk);
		check({ready_oe_n, irq_oe_n}, 2'b11);
		disconnect <= 1'b0;
		repeat (4) @(posedge clk);
		check({ready_oe_n, irq_oe_n}, 2'b00);
		check(n_drv > 0, 1'b1);
		finish_test();
	end
endmodule

`default_nettype wire
